// *** vm_event_params.svh ***
`ifndef VM_EVENT_PARAMS_SVH
`define VM_EVENT_PARAMS_SVH
// Register word indices, byte address is four times the index
`define IDX_CTRL 6'h00
`define IDX_GUEST 6'h01
`define IDX_INJECT 6'h02
`define IDX_CMD 6'h03
`define IDX_REASON 6'h04
`define IDX_INFO 6'h05
`define IDX_STATUS 6'h06
`define IDX_IRQ_STAT 6'h07
`define IDX_IRQ_MASK 6'h08
`define IDX_MC_STAT 6'h09
`define IDX_HOST 6'h0A
// Field positions
`define CTRL_EXT_EXIT 0
`define CTRL_ACK_EXIT 1
`define CTRL_WIN_EXIT 2
`define CTRL_MCE 3
`define CTRL_MC_BITMAP 4
`define GST_IF 0
`define GST_STI 1
`define GST_SS 2
`define GST_WFS 3
`define INJ_VALID 31
`define CMD_ENTRY 0
`define CMD_ON 1
`define CMD_OFF 2
`define HOST_IF 0
// Interrupt status bits
`define EV_EXIT 0
`define EV_ENTRY_FAIL 1
`define EV_ABORT 2
`define EV_SHUTDOWN 3
`define EV_HOST_MC 4
// Exit reasons
`define RSN_EXCEPTION 16'h0000
`define RSN_EXT_INT 16'h0001
`define RSN_STARTUP_INTERPROCESSOR_INTERRUPT 16'h0004
`define RSN_INT_WINDOW 16'h0007
`define RSN_ENTRY_GUEST 16'h0021
`define RSN_ENTRY_MC 16'h0029
// Abort indicator codes
`define ABT_NONE 3'h0
`define ABT_GUEST_MSR 3'h1
`define ABT_PDPTE 3'h2
`define ABT_CORRUPT 3'h3
`define ABT_HOST_MSR 3'h4
`define ABT_MC 3'h5
`define MC_VECTOR 8'h12
`endif

// *** vm_event_pkg.sv ***
package vm_event_pkg;
    typedef enum logic [3:0] {
        ST_OFF, ST_ON_OP, ST_OFF_OP, ST_ROOT, ST_ENTRY_CHK, ST_ENTRY_LOAD,
        ST_GUEST, ST_EXIT, ST_ABORT, ST_SHUTDOWN
    } vm_state_t;

    typedef struct packed {
        vm_state_t st;
        logic [4:0] ctrl;
        logic [3:0] guest;
        logic inj_valid;
        logic [7:0] inj_vec;
        logic [15:0] reason;
        logic info_valid;
        logic [7:0] info_vec;
        logic [2:0] abort_code;
        logic host_if;
        logic [4:0] irq_stat;
        logic [4:0] irq_mask;
        logic irq_s1;
        logic irq_s2;
        logic startup_interprocessor_interrupt_s1;
        logic startup_interprocessor_interrupt_s2;
        logic [7:0] vec_s1;
        logic [7:0] vec_s2;
        logic ack;
        logic [31:0] dat;
        logic irq;
        logic int_ack;
        logic gate_valid;
        logic [7:0] gate_vec;
        logic push;
        logic mc_exc;
        logic host_irq;
        logic in_guest;
        logic abort;
        logic shutdown;
    } vm_regs_t;
endpackage

// *** vm_transition_event_handling.sv ***
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "vm_event_params.svh"
module vm_transition_event_handling
    import vm_event_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    // Interrupt controller pins
    input wire logic ext_irq_i,
    input wire logic [7:0] ext_vector_i,
    input wire logic startup_ipi_i,
    output logic int_ack_o,
    // Core-side failure and check indications
    input wire logic machine_check_i,
    input wire logic guest_msr_fail_i,
    input wire logic pdpte_fail_i,
    input wire logic structure_corrupt_i,
    input wire logic host_msr_fail_i,
    input wire logic restart_pointer_valid_i,
    input wire logic error_pointer_valid_i,
    // Event delivery
    output logic gate_valid_o,
    output logic [7:0] gate_vector_o,
    output logic guest_push_o,
    output logic machine_check_exception_o,
    output logic host_irq_o,
    // Status
    output logic in_guest_o,
    output logic abort_o,
    output logic shutdown_o,
    output logic irq_o
);

    vm_regs_t q, d;

    logic bus_req;
    logic bus_wr;
    logic bus_rd;
    logic [5:0] idx;
    logic guest_ok;
    logic [2:0] fail_code;

    // Guest is interruptible only with flag set and both shadows clear
    function automatic logic guest_ready(input logic [3:0] g);
        guest_ready = g[`GST_IF] & ~g[`GST_STI] & ~g[`GST_SS];
    endfunction

    // Byte-lane merge for 32-bit writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        merge = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                merge[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
    endfunction

    assign bus_req = wb_cyc_i & wb_stb_i & ~q.ack;
    assign bus_wr = bus_req & wb_we_i;
    assign bus_rd = bus_req & ~wb_we_i;
    assign idx = wb_adr_i[7:2];
    assign guest_ok = guest_ready(q.guest);

    // Exit failure cause, checked while host state loads; first listed cause wins
    always_comb begin
        fail_code = `ABT_NONE;
        if (guest_msr_fail_i) begin
            fail_code = `ABT_GUEST_MSR;
        end else if (pdpte_fail_i) begin
            fail_code = `ABT_PDPTE;
        end else if (structure_corrupt_i) begin
            fail_code = `ABT_CORRUPT;
        end else if (host_msr_fail_i) begin
            fail_code = `ABT_HOST_MSR;
        end else if (machine_check_i) begin
            fail_code = `ABT_MC;
        end
    end

    // Next-state logic for the whole block
    always_comb begin
        logic [4:0] ev;
        logic [31:0] cmd;
        logic [31:0] wv;
        ev = 5'h00;
        cmd = 32'h0000_0000;
        wv = 32'h0000_0000;
        d = q;
        d.irq_s1 = ext_irq_i;
        d.irq_s2 = q.irq_s1;
        d.startup_interprocessor_interrupt_s1 = startup_ipi_i;
        d.startup_interprocessor_interrupt_s2 = q.startup_interprocessor_interrupt_s1;
        d.vec_s1 = ext_vector_i;
        d.vec_s2 = q.vec_s1;
        d.ack = bus_req;
        d.int_ack = 1'b0;
        d.gate_valid = 1'b0;
        d.push = 1'b0;
        d.mc_exc = 1'b0;

        // Register writes; command word only acts in the state it names
        if (bus_wr) begin
            case (idx)
                // Merged word is cut to the field width through a temporary
                `IDX_CTRL: begin
                    wv = merge({27'h0, q.ctrl}, wb_dat_i, wb_sel_i);
                    d.ctrl = wv[4:0];
                end
                `IDX_GUEST: begin
                    wv = merge({28'h0, q.guest}, wb_dat_i, wb_sel_i);
                    d.guest = wv[3:0];
                end
                `IDX_INJECT: begin
                    wv = merge({24'h0, q.inj_vec}, wb_dat_i, wb_sel_i);
                    d.inj_vec = wv[7:0];
                    if (wb_sel_i[3]) begin
                        d.inj_valid = wb_dat_i[`INJ_VALID];
                    end
                end
                `IDX_CMD: cmd = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
                `IDX_IRQ_MASK: begin
                    wv = merge({27'h0, q.irq_mask}, wb_dat_i, wb_sel_i);
                    d.irq_mask = wv[4:0];
                end
                `IDX_HOST: d.host_if = wb_sel_i[0] ? wb_dat_i[`HOST_IF] : q.host_if;
                default: ;
            endcase
        end

        // Transition sequencing
        case (q.st)
            ST_OFF: begin
                if (cmd[`CMD_ON]) begin
                    d.st = ST_ON_OP;
                end
            end
            ST_ON_OP, ST_OFF_OP: begin
                // Check during on/off: exception if enabled, otherwise shutdown
                if (machine_check_i && !q.ctrl[`CTRL_MCE]) begin
                    d.st = ST_SHUTDOWN;
                end else begin
                    d.mc_exc = machine_check_i;
                    ev[`EV_HOST_MC] = machine_check_i;
                    d.st = (q.st == ST_ON_OP) ? ST_ROOT : ST_OFF;
                end
            end
            ST_ROOT: begin
                if (cmd[`CMD_OFF]) begin
                    d.st = ST_OFF_OP;
                end else if (cmd[`CMD_ENTRY]) begin
                    d.st = ST_ENTRY_CHK;
                end
            end
            ST_ENTRY_CHK: begin
                // No guest state loaded yet: host-side delivery if enabled, otherwise shutdown
                if (machine_check_i) begin
                    if (q.ctrl[`CTRL_MCE]) begin
                        d.mc_exc = 1'b1;
                        ev[`EV_HOST_MC] = 1'b1;
                        d.st = ST_ROOT;
                    end else begin
                        d.st = ST_SHUTDOWN;
                    end
                end else if (q.inj_valid && !guest_ok) begin
                    d.reason = `RSN_ENTRY_GUEST;
                    d.host_if = 1'b0;
                    d.info_valid = 1'b0;
                    ev[`EV_ENTRY_FAIL] = 1'b1;
                    d.st = ST_ROOT;
                end else begin
                    d.st = ST_ENTRY_LOAD;
                end
            end
            ST_ENTRY_LOAD: begin
                if (machine_check_i) begin
                    // Guest state partly loaded, so only the host-load path is legal
                    d.reason = `RSN_ENTRY_MC;
                    d.st = ST_EXIT;
                end else begin
                    if (q.inj_valid) begin
                        d.gate_valid = 1'b1;
                        d.gate_vec = q.inj_vec;
                        d.push = 1'b1;
                        d.inj_valid = 1'b0;
                    end
                    d.st = ST_GUEST;
                end
            end
            ST_GUEST: begin
                if (machine_check_i) begin
                    if (q.ctrl[`CTRL_MC_BITMAP]) begin
                        d.reason = `RSN_EXCEPTION;
                        d.st = ST_EXIT;
                    end else begin
                        d.gate_valid = 1'b1;
                        d.gate_vec = `MC_VECTOR;
                        d.push = 1'b1;
                    end
                end else if (q.irq_s2 && q.ctrl[`CTRL_EXT_EXIT]) begin
                    d.reason = `RSN_EXT_INT;
                    d.st = ST_EXIT;
                end else if (q.startup_interprocessor_interrupt_s2 && q.guest[`GST_WFS]) begin
                    d.reason = `RSN_STARTUP_INTERPROCESSOR_INTERRUPT;
                    d.st = ST_EXIT;
                end else if (q.ctrl[`CTRL_WIN_EXIT] && guest_ok) begin
                    d.reason = `RSN_INT_WINDOW;
                    d.st = ST_EXIT;
                end
            end
            ST_EXIT: begin
                // Host state loads and is checked in this cycle
                if (fail_code != `ABT_NONE) begin
                    d.abort_code = fail_code;
                    d.st = ST_ABORT;
                end else begin
                    d.host_if = 1'b0;
                    d.info_valid = 1'b0;
                    if (q.reason == `RSN_EXT_INT && q.ctrl[`CTRL_ACK_EXIT]) begin
                        d.int_ack = 1'b1;
                        d.info_valid = 1'b1;
                        d.info_vec = q.vec_s2;
                    end
                    ev[`EV_EXIT] = 1'b1;
                    d.st = ST_ROOT;
                end
            end
            ST_ABORT: begin
                // All events are blocked until reset
                d.inj_valid = 1'b0;
            end
            ST_SHUTDOWN: begin
                d.inj_valid = 1'b0;
            end
            default: d.st = ST_OFF;
        endcase
        ev[`EV_ABORT] = (d.st == ST_ABORT) && (q.st != ST_ABORT);
        ev[`EV_SHUTDOWN] = (d.st == ST_SHUTDOWN) && (q.st != ST_SHUTDOWN);

        // Status levels registered so the pins come straight from flops
        d.in_guest = (d.st == ST_GUEST);
        d.abort = (d.st == ST_ABORT);
        d.shutdown = (d.st == ST_SHUTDOWN);

        // Host may vector the pending interrupt itself once it re-sets the flag
        d.host_irq = (q.st == ST_ROOT) && q.host_if && q.irq_s2;

        // Read data, sticky status cleared by its read; a new event wins
        d.dat = 32'h0000_0000;
        if (bus_rd) begin
            case (idx)
                `IDX_CTRL: d.dat = {27'h0, q.ctrl};
                `IDX_GUEST: d.dat = {28'h0, q.guest};
                `IDX_INJECT: d.dat = {q.inj_valid, 23'h0, q.inj_vec};
                `IDX_REASON: d.dat = {16'h0, q.reason};
                `IDX_INFO: d.dat = {q.info_valid, 23'h0, q.info_vec};
                `IDX_STATUS: d.dat = {21'h0, q.abort_code, q.host_if, 3'h0, q.st};
                `IDX_IRQ_STAT: d.dat = {27'h0, q.irq_stat};
                `IDX_IRQ_MASK: d.dat = {27'h0, q.irq_mask};
                `IDX_MC_STAT: d.dat = {30'h0, error_pointer_valid_i, restart_pointer_valid_i};
                `IDX_HOST: d.dat = {31'h0, q.host_if};
                default: d.dat = 32'h0000_0000;
            endcase
        end
        if (bus_rd && idx == `IDX_IRQ_STAT) begin
            d.irq_stat = ev;
        end else begin
            d.irq_stat = q.irq_stat | ev;
        end
        d.irq = |(d.irq_stat & d.irq_mask);
    end

    // Single state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.st <= ST_OFF;
        end else begin
            q <= d;
        end
    end

    // Every output straight from a flip-flop
    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.dat;
    assign int_ack_o = q.int_ack;
    assign gate_valid_o = q.gate_valid;
    assign gate_vector_o = q.gate_vec;
    assign guest_push_o = q.push;
    assign machine_check_exception_o = q.mc_exc;
    assign host_irq_o = q.host_irq;
    assign in_guest_o = q.in_guest;
    assign abort_o = q.abort;
    assign shutdown_o = q.shutdown;
    assign irq_o = q.irq;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence guest_ext_s;
        q.st == ST_GUEST && !machine_check_i && q.irq_s2 && q.ctrl[`CTRL_EXT_EXIT];
    endsequence

    sequence clean_exit_s;
        q.st == ST_EXIT && fail_code == `ABT_NONE;
    endsequence

    ext_int_exit_a: assert property (guest_ext_s |=> q.st == ST_EXIT && q.reason == 16'h0001)
        else $error("external interrupt did not force exit with reason 1");

    exit_clears_if_a: assert property (clean_exit_s |=> !q.host_if && q.st == ST_ROOT)
        else $error("exit left interrupt flag set");

    ack_on_exit_a: assert property (clean_exit_s ##0 (q.reason == `RSN_EXT_INT
        && q.ctrl[`CTRL_ACK_EXIT]) |=> int_ack_o && q.info_valid && q.info_vec == $past(q.vec_s2))
        else $error("acknowledge on exit missing or wrong vector");

    window_exit_a: assert property (q.st == ST_GUEST && !machine_check_i && !q.irq_s2
        && !q.startup_interprocessor_interrupt_s2 && q.ctrl[`CTRL_WIN_EXIT] && q.guest[`GST_IF]
        && !q.guest[`GST_STI] && !q.guest[`GST_SS] |=> q.reason == `RSN_INT_WINDOW)
        else $error("window exit not taken when guest became ready");

    one_inject_a: assert property (gate_valid_o && $past(q.st) == ST_ENTRY_LOAD |-> !q.inj_valid
        ##1 !gate_valid_o)
        else $error("injected event delivered more than once");

    entry_fail_a: assert property (q.st == ST_ENTRY_CHK && !machine_check_i && q.inj_valid
        && (!q.guest[`GST_IF] || q.guest[`GST_STI] || q.guest[`GST_SS])
        |=> q.st == ST_ROOT && !q.host_if && !gate_valid_o
        ##1 (q.irq_stat[`EV_ENTRY_FAIL] || $past(bus_rd)))
        else $error("entry into unready guest did not fail");

    exit_abort_a: assert property (q.st == ST_EXIT && (guest_msr_fail_i || pdpte_fail_i
        || host_msr_fail_i) |=> abort_o [*3])
        else $error("failed exit did not end in a lasting abort");

    onoff_mc_a: assert property ((q.st == ST_ON_OP || q.st == ST_OFF_OP) && machine_check_i
        |=> (q.ctrl[`CTRL_MCE] ? machine_check_exception_o : shutdown_o))
        else $error("on/off machine check handled wrongly");

    entry_mc_a: assert property (q.st == ST_ENTRY_LOAD && machine_check_i
        |=> q.st == ST_EXIT && q.reason == `RSN_ENTRY_MC)
        else $error("entry machine check after load not sent to host load");

    exit_mc_a: assert property (q.st == ST_EXIT && machine_check_i && fail_code == `ABT_MC
        |=> abort_o && q.abort_code == 3'h5)
        else $error("exit machine check did not record its abort cause");

    guest_mc_a: assert property (q.st == ST_GUEST && machine_check_i && !q.ctrl[`CTRL_MC_BITMAP]
        |=> gate_valid_o && gate_vector_o == 8'h12 && in_guest_o)
        else $error("guest machine check not sent through gate 12H");

endmodule
`default_nettype wire

// *** irq_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bench control
    input wire logic raise_i,
    input wire logic [7:0] vec_i,
    input wire logic drop_i,
    input wire logic startup_interprocessor_interrupt_i,
    // Link to the block
    input wire logic int_ack_i,
    output logic ext_irq_o,
    output logic [7:0] ext_vector_o,
    output logic startup_ipi_o
);
    logic [7:0] vec_q;
    // Level request stands until acknowledged or withdrawn, as a real controller would
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_irq_o <= 1'b0;
            vec_q <= 8'h00;
            startup_ipi_o <= 1'b0;
        end else begin
            startup_ipi_o <= startup_interprocessor_interrupt_i;
            if (raise_i) begin
                ext_irq_o <= 1'b1;
                vec_q <= vec_i;
            end else if (int_ack_i || drop_i) begin
                ext_irq_o <= 1'b0;
            end
        end
    end
    // Vector is only valid under a request; inverted otherwise so stale values cannot pass
    assign ext_vector_o = ext_irq_o ? vec_q : ~vec_q;
endmodule
`default_nettype wire

// *** vm_transition_event_handling_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "vm_event_params.svh"
module vm_transition_event_handling_test;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_wdat = 32'h0, wb_rdat, rd_q;
    logic wb_ack, ext_irq, startup_interprocessor_interrupt_line, int_ack, gate_valid, guest_push, mc_exc, host_irq;
    logic in_guest, abort, shutdown, irq;
    logic [7:0] ext_vec, gate_vec, raise_vec = 8'h00, last_gate = 8'h00;
    logic mc = 1'b0, rpv = 1'b0, epv = 1'b0, raise = 1'b0, drop = 1'b0, startup_interprocessor_interrupt = 1'b0;
    logic [3:0] fail = 4'h0;
    logic [31:0] unready[3] = '{32'h0, 32'h3, 32'h5};
    int bad_count = 0, cmp_count = 0, gate_n = 0, push_n = 0, exc_n = 0, ack_n = 0;

    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;

    vm_transition_event_handling vm_transition_event_handling_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_ack_o(wb_ack),
        .wb_dat_o(wb_rdat), .ext_irq_i(ext_irq), .ext_vector_i(ext_vec),
        .startup_ipi_i(startup_interprocessor_interrupt_line), .int_ack_o(int_ack), .machine_check_i(mc),
        .guest_msr_fail_i(fail[0]), .pdpte_fail_i(fail[1]), .structure_corrupt_i(fail[2]),
        .host_msr_fail_i(fail[3]), .restart_pointer_valid_i(rpv),
        .error_pointer_valid_i(epv), .gate_valid_o(gate_valid), .gate_vector_o(gate_vec),
        .guest_push_o(guest_push), .machine_check_exception_o(mc_exc),
        .host_irq_o(host_irq), .in_guest_o(in_guest), .abort_o(abort),
        .shutdown_o(shutdown), .irq_o(irq));

    irq_ctrl_model irq_ctrl_model_i (
        .clk_i(clk_i), .rst_i(rst_i), .raise_i(raise), .vec_i(raise_vec), .drop_i(drop),
        .startup_interprocessor_interrupt_i(startup_interprocessor_interrupt), .int_ack_i(int_ack), .ext_irq_o(ext_irq), .ext_vector_o(ext_vec),
        .startup_ipi_o(startup_interprocessor_interrupt_line));

    // Pulses counted at the edge, so each one-cycle pulse is seen exactly once
    always @(posedge clk_i) begin
        if (gate_valid === 1'b1) begin
            gate_n++;
            last_gate = gate_vec;
        end
        if (guest_push === 1'b1) push_n++;
        if (mc_exc === 1'b1) exc_n++;
        if (int_ack === 1'b1) ack_n++;
    end

    task automatic give_verdict();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic hang(input string what);
        bad_count++;
        $display("MISMATCH t=%0t %s never came", $time, what);
        give_verdict();
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Classic single cycle: hold until ack is sampled high, then release
    task automatic xfer(input logic we, input logic [5:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= {idx, 2'b00};
        wb_sel <= 4'hF;
        wb_wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        rd_q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        if (n >= 20) hang("bus ack");
    endtask

    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        xfer(1'b1, idx, d);
    endtask

    task automatic rd(input logic [5:0] idx, input logic [31:0] exp, input string what);
        xfer(1'b0, idx, 32'h0);
        check(rd_q, exp, what);
    endtask

    task automatic wait_guest(input logic lvl);
        int n;
        n = 0;
        while (in_guest !== lvl && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 40) hang("guest change");
    endtask

    task automatic do_reset();
        rst_i <= 1'b1;
        cycles(6);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic mc_pulse();
        mc <= 1'b1;
        @(posedge clk_i);
        mc <= 1'b0;
    endtask

    initial begin
        do_reset();
        rd(`IDX_STATUS, 32'h0, "status after reset");
        wr(6'h0F, 32'hFFFF_FFFF);
        rd(6'h0F, 32'h0, "unmapped read");
        wr(`IDX_IRQ_MASK, 32'h0000_001F);
        rd(`IDX_IRQ_MASK, 32'h0000_001F, "mask");
        wr(`IDX_CMD, 32'h1 << `CMD_ON);
        rd(`IDX_STATUS, 32'h0000_0003, "root after on");
        // External interrupt exit with acknowledge
        wr(`IDX_CTRL, 32'h0000_0003);
        wr(`IDX_GUEST, 32'h0000_0001);
        wr(`IDX_HOST, 32'h0000_0001);
        wr(`IDX_CMD, 32'h1 << `CMD_ENTRY);
        wait_guest(1'b1);
        raise_vec <= 8'h41;
        raise <= 1'b1;
        @(posedge clk_i);
        raise <= 1'b0;
        wait_guest(1'b0);
        cycles(3);
        rd(`IDX_REASON, {16'h0, `RSN_EXT_INT}, "reason ext");
        rd(`IDX_INFO, 32'h8000_0041, "info vector");
        check(ack_n, 1, "ack pulses");
        rd(`IDX_STATUS, 32'h0000_0003, "root, host flag clear");
        check(irq, 1'b1, "irq level");
        rd(`IDX_IRQ_STAT, 32'h1 << `EV_EXIT, "exit event");
        rd(`IDX_IRQ_STAT, 32'h0, "cleared on read");
        cycles(1);
        check(irq, 1'b0, "irq dropped");
        $display("test ext exit done");
        // No acknowledge: monitor re-enables the host flag itself
        wr(`IDX_CTRL, 32'h0000_0001);
        wr(`IDX_HOST, 32'h0000_0001);
        wr(`IDX_CMD, 32'h1 << `CMD_ENTRY);
        wait_guest(1'b1);
        raise_vec <= 8'h33;
        raise <= 1'b1;
        @(posedge clk_i);
        raise <= 1'b0;
        wait_guest(1'b0);
        cycles(3);
        check(host_irq, 1'b0, "masked after exit");
        wr(`IDX_HOST, 32'h0000_0001);
        cycles(2);
        check(host_irq, 1'b1, "host vectoring");
        check(ack_n, 1, "no ack");
        drop <= 1'b1;
        @(posedge clk_i);
        drop <= 1'b0;
        rd(`IDX_IRQ_STAT, 32'h1 << `EV_EXIT, "exit event");
        $display("test no-ack exit done");
        // Injection into an unready guest fails the entry
        foreach (unready[k]) begin
            wr(`IDX_GUEST, unready[k]);
            wr(`IDX_INJECT, 32'h8000_0020);
            wr(`IDX_CMD, 32'h1 << `CMD_ENTRY);
            cycles(4);
            check(in_guest, 1'b0, "entry refused");
            rd(`IDX_REASON, {16'h0, `RSN_ENTRY_GUEST}, "entry fail reason");
            xfer(1'b0, `IDX_IRQ_STAT, 32'h0);
            check(rd_q & (32'h1 << `EV_ENTRY_FAIL), 32'h1 << `EV_ENTRY_FAIL, "fail ev");
        end
        check(gate_n, 0, "no gate on failure");
        $display("test unready injection done");
        // Good injection, then window exits
        wr(`IDX_CTRL, 32'h0000_0004);
        wr(`IDX_GUEST, 32'h0000_0001);
        wr(`IDX_INJECT, 32'h8000_0030);
        wr(`IDX_CMD, 32'h1 << `CMD_ENTRY);
        cycles(8);
        check({gate_n[7:0], last_gate}, 16'h0130, "gate vector");
        check(push_n, 1, "guest push");
        rd(`IDX_INJECT, 32'h0000_0030, "inject consumed");
        rd(`IDX_REASON, {16'h0, `RSN_INT_WINDOW}, "window reason");
        wr(`IDX_CMD, 32'h1 << `CMD_ENTRY);
        cycles(8);
        check(gate_n, 1, "single event per entry");
        wr(`IDX_GUEST, 32'h0000_0003);
        wr(`IDX_CMD, 32'h1 << `CMD_ENTRY);
        wait_guest(1'b1);
        cycles(4);
        check(in_guest, 1'b1, "shadowed guest stays");
        wr(`IDX_GUEST, 32'h0000_0001);
        wait_guest(1'b0);
        rd(`IDX_REASON, {16'h0, `RSN_INT_WINDOW}, "window reason");
        $display("test injection and window done");
        // Startup interrupt with the target parked in wait-for-startup
        wr(`IDX_CTRL, 32'h0);
        wr(`IDX_GUEST, 32'h0000_0009);
        wr(`IDX_CMD, 32'h1 << `CMD_ENTRY);
        wait_guest(1'b1);
        startup_interprocessor_interrupt <= 1'b1;
        wait_guest(1'b0);
        startup_interprocessor_interrupt <= 1'b0;
        rd(`IDX_REASON, {16'h0, `RSN_STARTUP_INTERPROCESSOR_INTERRUPT}, "startup reason");
        // Guest machine check, bitmap clear then set
        wr(`IDX_GUEST, 32'h0000_0001);
        wr(`IDX_CMD, 32'h1 << `CMD_ENTRY);
        wait_guest(1'b1);
        mc_pulse();
        cycles(4);
        check(in_guest, 1'b1, "guest keeps running");
        check({gate_n[7:0], last_gate}, {8'h02, `MC_VECTOR}, "gate 12H");
        wr(`IDX_CTRL, 32'h1 << `CTRL_MC_BITMAP);
        mc_pulse();
        wait_guest(1'b0);
        rd(`IDX_REASON, {16'h0, `RSN_EXCEPTION}, "exception reason");
        rpv <= 1'b1;
        epv <= 1'b1;
        rd(`IDX_MC_STAT, 32'h0000_0003, "restart and error valid visible");
        $display("test guest events done");
        // Machine check during on, entry and off
        do_reset();
        wr(`IDX_CTRL, 32'h1 << `CTRL_MCE);
        mc <= 1'b1;
        wr(`IDX_CMD, 32'h1 << `CMD_ON);
        cycles(2);
        mc <= 1'b0;
        check(exc_n, 1, "exception on");
        rd(`IDX_STATUS, 32'h0000_0003, "root after on");
        mc <= 1'b1;
        wr(`IDX_CMD, 32'h1 << `CMD_ENTRY);
        cycles(2);
        mc <= 1'b0;
        check(exc_n, 2, "host delivery on entry");
        check(in_guest, 1'b0, "no guest");
        wr(`IDX_CTRL, 32'h0);
        mc <= 1'b1;
        wr(`IDX_CMD, 32'h1 << `CMD_OFF);
        cycles(2);
        mc <= 1'b0;
        check(shutdown, 1'b1, "shutdown");
        rd(`IDX_STATUS, 32'h0000_0009, "shutdown state");
        $display("test machine check done");
        // Each exit failure cause ends in an abort with its code
        // Fifth pass: a machine check lands exactly in the exit cycle
        for (int i = 1; i <= 5; i++) begin
            do_reset();
            wr(`IDX_CMD, 32'h1 << `CMD_ON);
            wr(`IDX_CTRL, 32'h0000_0004);
            wr(`IDX_GUEST, 32'h0000_0001);
            fail <= (i < 5) ? 4'h1 << (i - 1) : 4'h0;
            wr(`IDX_CMD, 32'h1 << `CMD_ENTRY);
            if (i == 5) begin
                cycles(2);
                mc_pulse();
            end
            cycles(8);
            fail <= 4'h0;
            check(abort, 1'b1, "abort");
            rd(`IDX_STATUS, 32'h8 | (i << 8), "abort code");
        end
        $display("test exit failures done");
        give_verdict();
    end

    // Whole-run guard
    initial begin
        #400000;
        hang("end of run");
    end
endmodule
`default_nettype wire
